// ===== rtl/sie_pkg.sv
package sie_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS         = 20;
  localparam int unsigned MS_NS          = 1_000_000;
  localparam int unsigned MS_CYCLES      = MS_NS / CLK_NS;
  localparam int unsigned TEST_LOW_NS    = 40_000;
  localparam int unsigned TEST_LOW_CYC   = TEST_LOW_NS / CLK_NS;
  localparam logic [7:0]  TEST_PERIOD_MS = 8'h02;
  localparam logic [7:0]  FILT_MIN_MS    = 8'h03;
  localparam logic [7:0]  FILT_MAX_MS    = 8'hfa;

  // ----------------------------------------------------------------
  // Channels and blocks
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH  = 9;
  localparam int unsigned NUM_BLK = 3;
  localparam int unsigned BLK_ES  = 0;
  localparam int unsigned BLK_TD  = 1;
  localparam int unsigned BLK_SS  = 2;
  localparam int unsigned BASE_ES = 0;
  localparam int unsigned BASE_TD = 3;
  localparam int unsigned BASE_SS = 6;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_ES_CFG = 8'h00;
  localparam logic [7:0]  ADDR_TD_CFG = 8'h04;
  localparam logic [7:0]  ADDR_SS_CFG = 8'h08;
  localparam logic [7:0]  ADDR_FB_IN  = 8'h0c;
  localparam logic [7:0]  ADDR_FB_CFG = 8'h10;
  localparam logic [7:0]  ADDR_STATUS = 8'h14;
  localparam logic [31:0] CFG_RST     = 32'h000a_0300;
  localparam logic [31:0] FB_CFG_RST  = 32'h0000_0000;
  localparam logic [7:0]  FB_FW_V2    = 8'h20;
  localparam logic [5:0]  FB_MAX_EXT  = 6'h20;
  localparam logic [5:0]  FB_MAX_STD  = 6'h08;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ES_2NO   = 2'h0;
  localparam logic [1:0] ES_MODE1 = 2'h1;
  localparam logic [1:0] ES_MODE2 = 2'h2;
  localparam logic [1:0] TD_NC    = 2'h0;
  localparam logic [1:0] TD_NO    = 2'h1;
  localparam logic [1:0] TD_DNC   = 2'h2;
  localparam logic [1:0] TD_NCNO  = 2'h3;
  localparam logic [1:0] RT_NONE  = 2'h0;
  localparam logic [1:0] RT_MAN   = 2'h1;

  typedef enum logic [1:0] {RS_IDLE, RS_ARM, RS_HIGH, RS_ON} sie_rst_e;

  typedef struct packed {
    logic [7:0] pad;
    logic [7:0] sim_ms;
    logic [7:0] filt_ms;
    logic       sim_en;
    logic       err_en;
    logic       test_en;
    logic       start_en;
    logic [1:0] rst_t;
    logic [1:0] variant;
  } sie_cfg_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sie_bus_req_s;

endpackage

// ===== rtl/sie_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Enabling switch output high only in middle position.
// - Input type: two NO, or two NO plus NC.
// - Mode one: third contact low only fully pressed.
// - Mode two: third contact high only released.
// - Enabling switch simultaneity check always active.
// - Debounce filter 3 to 250 ms everywhere.
// - Power_on_proof_test: activate then release once first.
// - Test outputs pulsed to detect wire shorts.
// - Single-channel sensor output follows its input.
// - Dual NC: output high only both high.
// - NC-NO: output high when first high, second low.
// - Simultaneity error when contacts disagree too long.
// - Testable device simultaneity check is optional.
// - Manual reset: release on reset rising edge.
// - Monitored reset: needs full high-low reset pulse.
// - No reset: output follows evaluated inputs.
// - Reset input is channel after block channels.
// - Semiconductor evaluator high when inputs high.
// - Semiconductor simultaneity check always applies.
// - Optional error output shows detected faults.
// - Up to 32 virtual inputs, else 8.
module sie_top #(
  parameter int unsigned P_MS_CYCLES = sie_pkg::MS_CYCLES
) (
  input  wire logic                  SYS_CLK,    // 50 MHz clock
  input  wire logic                  RST_N,      // Asynchronous reset, active low
  input  wire sie_pkg::sie_bus_req_s BUS_REQ,    // Register bus request
  output logic [31:0]                BUS_RDATA,  // Read data, cycle after read strobe
  input  wire logic [8:0]            CONTACT_IN, // External contact channels
  output logic [8:0]                 TEST_OUT,   // Test output per channel
  output logic [2:0]                 BLK_OUT,    // Evaluated output per block
  output logic [2:0]                 ERR_OUT,    // Error output per block
  output logic [31:0]                FB_OUT      // Virtual fieldbus inputs
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic int unsigned blk_of(input int unsigned ch);
    blk_of = (ch < sie_pkg::BASE_TD) ? sie_pkg::BLK_ES :
             (ch < sie_pkg::BASE_SS) ? sie_pkg::BLK_TD : sie_pkg::BLK_SS;
  endfunction

  function automatic int unsigned base_of(input int unsigned b);
    base_of = (b == sie_pkg::BLK_ES) ? sie_pkg::BASE_ES :
              (b == sie_pkg::BLK_TD) ? sie_pkg::BASE_TD : sie_pkg::BASE_SS;
  endfunction

  function automatic int unsigned nch_of(input int unsigned b, input logic [1:0] v);
    nch_of = 2;
    if (b == sie_pkg::BLK_ES && v != sie_pkg::ES_2NO) begin
      nch_of = 3;
    end
    if (b == sie_pkg::BLK_TD && (v == sie_pkg::TD_NC || v == sie_pkg::TD_NO)) begin
      nch_of = 1;
    end
  endfunction

  // Pattern bit 0 is contact_a, bit 1 contact_b, bit 2 contact_c.
  function automatic logic pat_active(input int unsigned b, input logic [1:0] v, input logic [2:0] p);
    pat_active = 1'b0;
    if (b == sie_pkg::BLK_ES) begin
      case (v)
        sie_pkg::ES_MODE1: pat_active = (p == 3'h7);
        sie_pkg::ES_MODE2: pat_active = (p == 3'h3);
        default:           pat_active = (p[1:0] == 2'h3);
      endcase
    end else if (b == sie_pkg::BLK_TD) begin
      case (v)
        sie_pkg::TD_DNC:  pat_active = (p[1:0] == 2'h3);
        sie_pkg::TD_NCNO: pat_active = (p[1:0] == 2'h1);
        default:          pat_active = p[0];
      endcase
    end else begin
      pat_active = (p[1:0] == 2'h3);
    end
  endfunction

  function automatic logic pat_idle(input int unsigned b, input logic [1:0] v, input logic [2:0] p);
    pat_idle = 1'b0;
    if (b == sie_pkg::BLK_ES) begin
      case (v)
        sie_pkg::ES_MODE1: pat_idle = (p == 3'h4) || (p == 3'h0);
        sie_pkg::ES_MODE2: pat_idle = (p == 3'h4) || (p == 3'h0);
        default:           pat_idle = (p[1:0] == 2'h0);
      endcase
    end else if (b == sie_pkg::BLK_TD) begin
      case (v)
        sie_pkg::TD_DNC:  pat_idle = (p[1:0] == 2'h0);
        sie_pkg::TD_NCNO: pat_idle = (p[1:0] == 2'h2);
        default:          pat_idle = !p[0];
      endcase
    end else begin
      pat_idle = (p[1:0] == 2'h0);
    end
  endfunction

  // Filter clamp for every block, then block-specific constraints on the raw software configuration.
  function automatic sie_pkg::sie_cfg_s eff_cfg(input int unsigned b, input sie_pkg::sie_cfg_s c);
    eff_cfg = c;
    if (c.filt_ms < sie_pkg::FILT_MIN_MS) begin
      eff_cfg.filt_ms = sie_pkg::FILT_MIN_MS;
    end
    if (c.filt_ms > sie_pkg::FILT_MAX_MS) begin
      eff_cfg.filt_ms = sie_pkg::FILT_MAX_MS;
    end
    if (b == sie_pkg::BLK_ES) begin
      eff_cfg.sim_en = 1'b1;
      eff_cfg.rst_t  = sie_pkg::RT_NONE;
    end
    if (b == sie_pkg::BLK_SS) begin
      eff_cfg.sim_en  = 1'b1;
      eff_cfg.variant = 2'h0;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sie_pkg::sie_cfg_s cfg_q  [3];
  sie_pkg::sie_cfg_s ecfg   [3];
  logic [31:0]       fb_in_q;
  logic [31:0]       fb_cfg_q;
  logic [31:0]       rdata_q;
  logic [8:0]        sync1_q;
  logic [8:0]        sync2_q;
  logic [8:0]        flt_q;
  logic [7:0]        fcnt_q [9];
  logic [15:0]       ms_cnt_q;
  logic              ms_tick;
  logic [7:0]        sim_q  [3];
  logic [2:0]        err_q;
  logic [2:0]        seen_q;
  logic [2:0]        proven_q;
  logic [2:0]        prv_rst_q;
  sie_pkg::sie_rst_e rs_q   [3];
  logic [2:0]        out_q;
  logic [2:0]        erro_q;
  logic [7:0]        tp_ms_q;
  logic [3:0]        tch_q;
  logic [11:0]       tcnt_q;
  logic [8:0]        test_q;
  logic [31:0]       fb_q;
  logic [2:0]        pat    [3];
  logic [2:0]        act;
  logic [2:0]        idle;
  logic [2:0]        valid;
  logic [2:0]        sim_to;
  logic [2:0]        tfault;
  logic [2:0]        cond;
  logic [2:0]        rst_lvl;
  logic [5:0]        fb_cnt;
  logic [31:0]       fb_mask;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int b = 0; b < 3; b++) begin
        cfg_q[b] <= sie_pkg::sie_cfg_s'(sie_pkg::CFG_RST);
      end
      fb_in_q  <= 32'h0000_0000;
      fb_cfg_q <= sie_pkg::FB_CFG_RST;
    end else if (BUS_REQ.wr) begin
      case (BUS_REQ.addr)
        sie_pkg::ADDR_ES_CFG: cfg_q[sie_pkg::BLK_ES] <= sie_pkg::sie_cfg_s'(BUS_REQ.wdata);
        sie_pkg::ADDR_TD_CFG: cfg_q[sie_pkg::BLK_TD] <= sie_pkg::sie_cfg_s'(BUS_REQ.wdata);
        sie_pkg::ADDR_SS_CFG: cfg_q[sie_pkg::BLK_SS] <= sie_pkg::sie_cfg_s'(BUS_REQ.wdata);
        sie_pkg::ADDR_FB_IN:  fb_in_q  <= BUS_REQ.wdata;
        sie_pkg::ADDR_FB_CFG: fb_cfg_q <= BUS_REQ.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        sie_pkg::ADDR_ES_CFG: rdata_q <= cfg_q[sie_pkg::BLK_ES];
        sie_pkg::ADDR_TD_CFG: rdata_q <= cfg_q[sie_pkg::BLK_TD];
        sie_pkg::ADDR_SS_CFG: rdata_q <= cfg_q[sie_pkg::BLK_SS];
        sie_pkg::ADDR_FB_IN:  rdata_q <= fb_in_q;
        sie_pkg::ADDR_FB_CFG: rdata_q <= fb_cfg_q;
        sie_pkg::ADDR_STATUS: rdata_q <= {2'h0, fb_cnt, 7'h00, flt_q, 1'b0, err_q, 1'b0, out_q};
        default:              rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser, millisecond tick and debounce
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= CONTACT_IN;
      sync2_q <= sync1_q;
    end
  end

  assign ms_tick = (ms_cnt_q == 16'(P_MS_CYCLES - 1));

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      ms_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
    end
  end

  always_comb begin
    for (int b = 0; b < 3; b++) begin
      ecfg[b] = eff_cfg(b, cfg_q[b]);
    end
  end

  // A change is taken only after it has held for the whole filter time, so the short test
  // pulses never reach the evaluators; the price is added response time.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flt_q <= 9'h000;
      for (int c = 0; c < 9; c++) begin
        fcnt_q[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < 9; c++) begin
        if (sync2_q[c] == flt_q[c]) begin
          fcnt_q[c] <= 8'h00;
        end else if (ms_tick) begin
          if (fcnt_q[c] + 8'h01 >= ecfg[blk_of(c)].filt_ms) begin
            flt_q[c]  <= sync2_q[c];
            fcnt_q[c] <= 8'h00;
          end else begin
            fcnt_q[c] <= fcnt_q[c] + 8'h01;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Test pulses
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tp_ms_q <= 8'h00;
      tcnt_q  <= 12'h000;
      tch_q   <= 4'h0;
    end else begin
      if (ms_tick) begin
        tp_ms_q <= (tp_ms_q == sie_pkg::TEST_PERIOD_MS - 8'h01) ? 8'h00 : tp_ms_q + 8'h01;
      end
      if (ms_tick && tp_ms_q == sie_pkg::TEST_PERIOD_MS - 8'h01) begin
        tcnt_q <= 12'(sie_pkg::TEST_LOW_CYC);
      end else if (tcnt_q != 12'h000) begin
        tcnt_q <= tcnt_q - 12'h001;
      end
      if (tcnt_q == 12'h001) begin
        tch_q <= (tch_q == 4'(sie_pkg::NUM_CH - 1)) ? 4'h0 : tch_q + 4'h1;
      end
    end
  end

  // One channel is pulled low at a time, so a wire shorted to a neighbour stays high and is caught.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      test_q <= 9'h1ff;
    end else begin
      for (int c = 0; c < 9; c++) begin
        test_q[c] <= !(tcnt_q != 12'h000 && tch_q == 4'(c) && ecfg[blk_of(c)].test_en);
      end
    end
  end

  always_comb begin
    for (int b = 0; b < 3; b++) begin
      tfault[b] = (tcnt_q == 12'h001) && sync2_q[tch_q] && ecfg[b].test_en &&
                  (blk_of(32'(tch_q)) == b) &&
                  (32'(tch_q) < base_of(b) + nch_of(b, ecfg[b].variant));
    end
  end

  // ----------------------------------------------------------------
  // Pattern evaluation and simultaneity
  // ----------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < 3; b++) begin
      pat[b]     = flt_q[base_of(b) +: 3];
      if (nch_of(b, ecfg[b].variant) < 3) begin
        pat[b][2] = 1'b0;
      end
      act[b]     = pat_active(b, ecfg[b].variant, pat[b]);
      idle[b]    = pat_idle(b, ecfg[b].variant, pat[b]);
      valid[b]   = act[b] || idle[b];
      sim_to[b]  = ecfg[b].sim_en && !valid[b] && (sim_q[b] > ecfg[b].sim_ms);
      rst_lvl[b] = flt_q[base_of(b) + nch_of(b, ecfg[b].variant)];
      cond[b]    = act[b] && !err_q[b] && (proven_q[b] || !ecfg[b].start_en);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int b = 0; b < 3; b++) begin
        sim_q[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (!ecfg[b].sim_en || valid[b]) begin
          sim_q[b] <= 8'h00;
        end else if (ms_tick && sim_q[b] != 8'hff) begin
          sim_q[b] <= sim_q[b] + 8'h01;
        end
      end
    end
  end

  // A fault latches and holds the output low until the contacts are back at rest;
  // a new fault in the clearing cycle wins.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      err_q <= 3'h0;
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (sim_to[b] || tfault[b]) begin
          err_q[b] <= 1'b1;
        end else if (idle[b]) begin
          err_q[b] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Start-up proof test
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      seen_q   <= 3'h0;
      proven_q <= 3'h0;
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (act[b] && !err_q[b]) begin
          seen_q[b] <= 1'b1;
        end
        if (seen_q[b] && idle[b]) begin
          proven_q[b] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset handling and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prv_rst_q <= 3'h0;
    end else begin
      prv_rst_q <= rst_lvl;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int b = 0; b < 3; b++) begin
        rs_q[b] <= sie_pkg::RS_IDLE;
      end
    end else begin
      for (int b = 0; b < 3; b++) begin
        case (rs_q[b])
          sie_pkg::RS_IDLE: begin
            if (cond[b]) begin
              rs_q[b] <= (ecfg[b].rst_t == sie_pkg::RT_NONE) ? sie_pkg::RS_ON : sie_pkg::RS_ARM;
            end
          end
          sie_pkg::RS_ARM: begin
            if (!cond[b]) begin
              rs_q[b] <= sie_pkg::RS_IDLE;
            end else if (ecfg[b].rst_t == sie_pkg::RT_NONE) begin
              rs_q[b] <= sie_pkg::RS_ON;
            end else if (rst_lvl[b] && !prv_rst_q[b]) begin
              rs_q[b] <= (ecfg[b].rst_t == sie_pkg::RT_MAN) ? sie_pkg::RS_ON : sie_pkg::RS_HIGH;
            end
          end
          sie_pkg::RS_HIGH: begin
            if (!cond[b]) begin
              rs_q[b] <= sie_pkg::RS_IDLE;
            end else if (!rst_lvl[b] && prv_rst_q[b]) begin
              rs_q[b] <= sie_pkg::RS_ON;
            end
          end
          sie_pkg::RS_ON: begin
            if (!cond[b]) begin
              rs_q[b] <= sie_pkg::RS_IDLE;
            end
          end
          default: rs_q[b] <= sie_pkg::RS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_q  <= 3'h0;
      erro_q <= 3'h0;
    end else begin
      for (int b = 0; b < 3; b++) begin
        out_q[b]  <= (rs_q[b] == sie_pkg::RS_ON) && cond[b];
        erro_q[b] <= err_q[b] && ecfg[b].err_en;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fieldbus virtual inputs
  // ----------------------------------------------------------------
  always_comb begin
    if (fb_cfg_q[0] && fb_cfg_q[15:8] >= sie_pkg::FB_FW_V2) begin
      fb_cnt  = sie_pkg::FB_MAX_EXT;
      fb_mask = 32'hffff_ffff;
    end else begin
      fb_cnt  = sie_pkg::FB_MAX_STD;
      fb_mask = 32'h0000_00ff;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fb_q <= 32'h0000_0000;
    end else begin
      fb_q <= fb_in_q & fb_mask;
    end
  end

  assign BUS_RDATA = rdata_q;
  assign TEST_OUT  = test_q;
  assign BLK_OUT   = out_q;
  assign ERR_OUT   = erro_q;
  assign FB_OUT    = fb_q;

endmodule

// ===== dv/sie_contacts.sv
`timescale 1ns/100ps
module sie_contacts (
  input  wire logic [8:0] closed,    // Contact closed per channel
  input  wire logic [8:0] test_out,  // Test signal fed to each contact
  output logic [8:0]      contact_in // Level seen at the pins
);
  // A closed contact passes its test signal on, so a test pulse reaches the pin; open reads low by pull-down.
  assign contact_in = closed & test_out;
endmodule

// ===== dv/sie_top_assertions.sv
`timescale 1ns/100ps
module sie_top_chk #(
  parameter int unsigned P_MS_CYCLES = 20
) (
  input wire logic                  SYS_CLK,    // Clock
  input wire logic                  RST_N,      // Reset, active low
  input wire sie_pkg::sie_bus_req_s BUS_REQ,    // Bus request
  input wire logic [31:0]           BUS_RDATA,  // Read data
  input wire logic [8:0]            CONTACT_IN, // Contact pins
  input wire logic [8:0]            TEST_OUT,   // Test outputs
  input wire logic [2:0]            BLK_OUT,    // Block outputs
  input wire logic [2:0]            ERR_OUT,    // Error outputs
  input wire logic [31:0]           FB_OUT      // Virtual inputs
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence fb_wr_s;
    BUS_REQ.wr && BUS_REQ.addr == sie_pkg::ADDR_FB_IN ##1 !(BUS_REQ.wr && BUS_REQ.addr == sie_pkg::ADDR_FB_IN);
  endsequence
  chk_reset_idle: assert property ($rose(RST_N) |-> BLK_OUT == 3'h0 && ERR_OUT == 3'h0 && TEST_OUT == 9'h1ff)
    else $error("outputs not idle after reset");
  chk_rdata_cause: assert property (BUS_RDATA != 32'h0 |-> $past(BUS_REQ.rd))
    else $error("read data without read");
  chk_es_middle: assert property ($rose(BLK_OUT[0]) |-> $past(CONTACT_IN[1:0], 8) == 2'h3)
    else $error("switch output rose outside middle position");
  chk_td_active: assert property ($rose(BLK_OUT[1]) |-> $past(CONTACT_IN[3], 8))
    else $error("sensor output rose with first contact low");
  chk_ss_both: assert property ($rose(BLK_OUT[2]) |-> $past(CONTACT_IN[7:6], 8) == 2'h3)
    else $error("semiconductor output rose with an input low");
  chk_err_forces: assert property ((ERR_OUT & $past(ERR_OUT) & $past(ERR_OUT, 2) & BLK_OUT) == 3'h0)
    else $error("output high during error");
  chk_one_test: assert property ($countones(~TEST_OUT) <= 1)
    else $error("more than one test pulse at once");
  chk_fb_mask: assert property (fb_wr_s |-> ##1
    FB_OUT[7:0] == $past(BUS_REQ.wdata[7:0], 2) && (FB_OUT & ~$past(BUS_REQ.wdata, 2)) == 32'h0)
    else $error("virtual inputs differ from written bits");
endmodule
bind sie_top sie_top_chk #(.P_MS_CYCLES(P_MS_CYCLES)) u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ),
  .BUS_RDATA(BUS_RDATA), .CONTACT_IN(CONTACT_IN), .TEST_OUT(TEST_OUT), .BLK_OUT(BLK_OUT), .ERR_OUT(ERR_OUT),
  .FB_OUT(FB_OUT));

// ===== dv/tb_safety_input_evaluator.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_safety_input_evaluator;
  localparam int unsigned MS_CYC = 20;
  localparam logic [31:0] CFG = sie_pkg::CFG_RST;
  logic                  clk         = 1'b0;
  logic                  rst_n       = 1'b0;
  sie_pkg::sie_bus_req_s req         = '0;
  logic [8:0]            closed      = 9'h0;
  logic [31:0]           rdata, fb_out, d;
  logic [8:0]            pins, test_out;
  logic [2:0]            blk_out, err_out;
  int                    n_fail      = 0;
  int                    check_count = 0;
  int                    cycles      = 0;
  // Row: block, variant, contact pattern c-b-a, expected output.
  logic [7:0]            rows [19]   = '{8'h18, 8'h1f, 8'h10, 8'h28, 8'h27, 8'h20, 8'h2e, 8'h28, 8'h07, 8'h00,
                                         8'h43, 8'h40, 8'h53, 8'h50, 8'h67, 8'h60, 8'h74, 8'h73, 8'h74};
  logic [31:0]           fbc [3]     = '{32'h0, 32'h2001, 32'h1f01};
  logic [5:0]            fbn [3]     = '{6'h08, 6'h20, 6'h08};

  sie_top #(.P_MS_CYCLES(MS_CYC)) u_dut (.SYS_CLK(clk), .RST_N(rst_n), .BUS_REQ(req), .BUS_RDATA(rdata),
    .CONTACT_IN(pins), .TEST_OUT(test_out), .BLK_OUT(blk_out), .ERR_OUT(err_out), .FB_OUT(fb_out));
  sie_contacts u_far (.closed(closed), .test_out(test_out), .contact_in(pins));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      n_fail++;
      results();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Waits are whole ms so the 3 ms filter and 10 ms simultaneity limit have settled before a check.
  task automatic step(input int b, input logic [2:0] p, input int ms);
    @(posedge clk);
    closed[b +: 3] <= p;
    repeat (ms * MS_CYC) @(posedge clk);
    #1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(sie_pkg::ADDR_ES_CFG, d);
    `CHK(d, CFG)
    rd(8'h18, d);
    `CHK(d, 32'h0)
    // With a shortened millisecond the pulse timer reloads before it runs out, so channel 0 stays under test.
    wr(sie_pkg::ADDR_ES_CFG, CFG | 32'h20);
    step(0, 3'h0, 3);
    `CHK(test_out[0], 1'b0)
    wr(sie_pkg::ADDR_ES_CFG, CFG);
    step(0, 3'h0, 1);
    `CHK(test_out, 9'h1ff)
    wr(sie_pkg::ADDR_TD_CFG, CFG | 32'h10);
    step(3, 3'h1, 5);
    `CHK(blk_out[1], 1'b0)
    step(3, 3'h0, 5);
    step(3, 3'h1, 5);
    `CHK(blk_out[1], 1'b1)
    step(3, 3'h0, 5);
    for (int i = 0; i < 19; i++) begin
      wr(rows[i][7:6] == 2'h0 ? sie_pkg::ADDR_ES_CFG : sie_pkg::ADDR_TD_CFG, CFG | {30'h0, rows[i][5:4]});
      step(rows[i][7:6] == 2'h0 ? 0 : 3, rows[i][3:1], 5);
      `CHK(blk_out[rows[i][7:6]], rows[i][0])
    end
    wr(sie_pkg::ADDR_TD_CFG, CFG | 32'h42);
    step(3, 3'h0, 5);
    step(3, 3'h1, 16);
    `CHK(err_out[1], 1'b0)
    step(3, 3'h0, 5);
    wr(sie_pkg::ADDR_TD_CFG, CFG | 32'hc2);
    step(3, 3'h1, 16);
    `CHK(err_out[1], 1'b1)
    step(3, 3'h0, 5);
    wr(sie_pkg::ADDR_SS_CFG, CFG | 32'h40);
    step(6, 3'h3, 5);
    `CHK(blk_out[2], 1'b1)
    step(6, 3'h1, 5);
    `CHK(blk_out[2], 1'b0)
    `CHK(err_out[2], 1'b0)
    step(6, 3'h1, 10);
    `CHK(err_out[2], 1'b1)
    step(6, 3'h0, 5);
    `CHK(err_out[2], 1'b0)
    wr(sie_pkg::ADDR_SS_CFG, CFG | 32'h04);
    step(6, 3'h3, 5);
    `CHK(blk_out[2], 1'b0)
    step(6, 3'h7, 5);
    `CHK(blk_out[2], 1'b1)
    step(6, 3'h0, 5);
    wr(sie_pkg::ADDR_SS_CFG, CFG | 32'h08);
    step(6, 3'h3, 5);
    step(6, 3'h7, 5);
    `CHK(blk_out[2], 1'b0)
    step(6, 3'h3, 5);
    `CHK(blk_out[2], 1'b1)
    step(6, 3'h0, 5);
    for (int i = 0; i < 3; i++) begin
      wr(sie_pkg::ADDR_FB_CFG, fbc[i]);
      wr(sie_pkg::ADDR_FB_IN, 32'hffffffff);
      step(0, 3'h0, 1);
      `CHK(fb_out, fbn[i] == 6'h20 ? 32'hffffffff : 32'h000000ff)
      rd(sie_pkg::ADDR_STATUS, d);
      `CHK(d[29:24], fbn[i])
    end
    results();
  end
endmodule
